/* rtl/tbfsv_pkg.sv */
/*
  constants, carrier types and register map of the transmit buffer fill and
  transmit status vector block.
  assumes one 25 MHz system clock and byte-wide host register strobes.
*/
package tbfsv_pkg;

  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFF_SEQ_WR = 8'h03;
  localparam logic [7:0] OFF_END_HI = 8'h57;
  localparam logic [7:0] OFF_END_LO = 8'h58;
  localparam logic [7:0] OFF_STAT6 = 8'h5C;
  localparam logic [7:0] OFF_STAT5 = 8'h5D;
  localparam logic [7:0] OFF_STAT4 = 8'h5E;
  localparam logic [7:0] OFF_STAT3 = 8'h5F;
  localparam logic [7:0] OFF_STAT2 = 8'h60;
  localparam logic [7:0] OFF_STAT1 = 8'h61;
  localparam logic [7:0] OFF_STAT0 = 8'h62;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] PTR_RESET = 16'h0000;
  localparam logic [3:0] UNUSED_NIBBLE = 4'h0;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int LATE_WINDOW_NS = 51200;
  localparam int LATE_WINDOW_CYC = LATE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int EXCESS_DELAY_NS = 2420000;
  localparam int EXCESS_DELAY_CYC = EXCESS_DELAY_NS / CLK_PERIOD_NS;

  // -------------------------------------------------------------------------
  // collision limits
  // -------------------------------------------------------------------------
  localparam logic [4:0] COL_LIMIT = 5'h10;
  localparam logic [3:0] COL_FIELD_MAX = 4'hF;

  // -------------------------------------------------------------------------
  // carrier types
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tbfsv_host_req_t;

  typedef struct packed {
    logic tx_start;
    logic attempt_start;
    logic wire_byte;
    logic collision;
    logic underrun;
    logic tx_end;
  } tbfsv_mac_evt_t;

  typedef struct packed {
    logic vlan;
    logic back_pressure;
    logic pause;
    logic control;
    logic bcast;
    logic mcast;
    logic type_field;
    logic len_err;
    logic crc_err;
  } tbfsv_frame_info_t;

  // bit order equals status vector bits 51..0
  typedef struct packed {
    logic vlan_tag_flag;
    logic back_pressure_flag;
    logic pause_frame_flag;
    logic control_frame_flag;
    logic [15:0] wire_bytes;
    logic underrun_flag;
    logic reserved;
    logic late_collision_flag;
    logic excessive_collision_flag;
    logic excessive_delay_flag;
    logic delay_flag;
    logic broadcast_dest_flag;
    logic multicast_dest_flag;
    logic send_success_flag;
    logic type_field_flag;
    logic length_mismatch_flag;
    logic crc_mismatch_flag;
    logic [3:0] collision_count;
    logic [15:0] frame_bytes;
  } tbfsv_stat_t;

endpackage

/* rtl/tbfsv_buf.sv */
/*
  two-entry valid/ready buffer between the host write port and the buffer ram.
  assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tbfsv_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } tbfsv_buf_state_t;

  tbfsv_buf_state_t s_reg;
  tbfsv_buf_state_t s_next;
  logic push;
  logic pop;

  assign in_ready_o = (s_reg.cnt != (PW+1)'(DEPTH));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o = s_reg.mem[s_reg.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp = (s_reg.wp == PW'(DEPTH - 1)) ? '0 : s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = (s_reg.rp == PW'(DEPTH - 1)) ? '0 : s_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: s_next.cnt = s_reg.cnt + 1'b1;
      2'b01: s_next.cnt = s_reg.cnt - 1'b1;
      default: s_next.cnt = s_reg.cnt;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule

`default_nettype wire

/* rtl/tbfsv_top.sv */
/*
  transmit buffer fill port, end pointer and transmit status vector registers.
  assumes the host strobes are synchronous one-cycle requests and the mac
  reports its transmit events as one-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tbfsv_top
  import tbfsv_pkg::*;
#(
  parameter int BUF_AW = 11,
  parameter int EXCESS_DELAY_CYCLES = EXCESS_DELAY_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // host register port
  input wire tbfsv_host_req_t host_req_i,
  output logic host_wr_ready_o,
  output logic [7:0] host_rdata_o,
  // mac side
  input wire tbfsv_mac_evt_t mac_evt_i,
  input wire tbfsv_frame_info_t frame_info_i,
  input wire logic mac_rd_i,
  input wire logic [BUF_AW-1:0] mac_rd_addr_i,
  output logic [7:0] mac_rdata_o,
  output logic mac_abort_o,
  output logic [15:0] mac_end_ptr_o
);

  localparam int BW = BUF_AW + 8;

  typedef struct packed {
    logic [15:0] end_ptr;
    logic [BUF_AW-1:0] wr_addr;
    logic [7:0] rdata;
    logic [7:0] mac_rdata;
    logic active;
    logic abort;
    logic late;
    logic [4:0] col_cnt;
    logic [15:0] win_cnt;
    logic [19:0] del_cnt;
    logic [15:0] wire_cnt;
    logic [15:0] frame_cnt;
    tbfsv_stat_t stat;
  } tbfsv_state_t;

  tbfsv_state_t s_reg;
  tbfsv_state_t s_next;
  logic [7:0] tx_ram [2**BUF_AW];

  logic seq_push;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [BW-1:0] buf_out_data;
  logic ram_we;
  logic cap;
  logic col_hit;
  logic excess;
  logic finish_abort;
  logic [7:0] rd_mux;
  logic [51:0] stat_bits;

  // -------------------------------------------------------------------------
  // host write path through the two-entry buffer
  // -------------------------------------------------------------------------
  // a full buffer refuses the write; the host sees host_wr_ready_o low
  assign seq_push = host_req_i.wr && (host_req_i.addr == OFF_SEQ_WR) && buf_in_ready;
  assign host_wr_ready_o = buf_in_ready;
  // mac reads own the single ram port, so the buffer drains only when idle
  assign ram_we = buf_out_valid && !mac_rd_i;

  tbfsv_buf #(
    .W(BW),
    .DEPTH(2)
  ) u_buf (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(host_req_i.wr && (host_req_i.addr == OFF_SEQ_WR)),
    .in_ready_o(buf_in_ready),
    .in_data_i({s_reg.wr_addr, host_req_i.wdata}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(!mac_rd_i),
    .out_data_o(buf_out_data)
  );

  always_ff @(posedge clk_i) begin
    if (ram_we) begin
      tx_ram[buf_out_data[BW-1:8]] <= buf_out_data[7:0];
    end
  end

  // -------------------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------------------
  assign stat_bits = s_reg.stat;

  always_comb begin
    case (host_req_i.addr)
      OFF_END_HI: rd_mux = s_reg.end_ptr[15:8];
      OFF_END_LO: rd_mux = s_reg.end_ptr[7:0];
      OFF_STAT6: rd_mux = {UNUSED_NIBBLE, stat_bits[51:48]};
      OFF_STAT5: rd_mux = stat_bits[47:40];
      OFF_STAT4: rd_mux = stat_bits[39:32];
      OFF_STAT3: rd_mux = stat_bits[31:24];
      OFF_STAT2: rd_mux = stat_bits[23:16];
      OFF_STAT1: rd_mux = stat_bits[15:8];
      OFF_STAT0: rd_mux = stat_bits[7:0];
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  // -------------------------------------------------------------------------
  // transmit tracking and status capture
  // -------------------------------------------------------------------------
  // judged on the registered count, so no loop runs back through s_next
  assign col_hit = s_reg.active && !mac_evt_i.tx_start && mac_evt_i.collision;
  assign excess = col_hit && (s_reg.col_cnt >= COL_LIMIT - 5'h01);
  assign cap = s_reg.active && (mac_evt_i.tx_end || mac_evt_i.underrun || excess);
  assign finish_abort = mac_evt_i.underrun || excess;

  always_comb begin
    s_next = s_reg;
    s_next.abort = 1'b0;
    if (host_req_i.rd) begin
      s_next.rdata = rd_mux;
    end
    if (mac_rd_i) begin
      s_next.mac_rdata = tx_ram[mac_rd_addr_i];
    end
    if (host_req_i.wr && (host_req_i.addr == OFF_END_HI)) begin
      s_next.end_ptr[15:8] = host_req_i.wdata;
    end
    if (host_req_i.wr && (host_req_i.addr == OFF_END_LO)) begin
      s_next.end_ptr[7:0] = host_req_i.wdata;
    end
    if (seq_push) begin
      s_next.end_ptr = 16'(s_reg.wr_addr);
      s_next.wr_addr = s_reg.wr_addr + 1'b1;
    end
    if (mac_evt_i.tx_start) begin
      // each packet is built from address zero again
      s_next.wr_addr = '0;
      s_next.active = 1'b1;
      s_next.late = 1'b0;
      s_next.col_cnt = '0;
      s_next.win_cnt = '0;
      s_next.del_cnt = '0;
      s_next.wire_cnt = '0;
      s_next.frame_cnt = '0;
    end else if (s_reg.active) begin
      if (s_reg.win_cnt != 16'hFFFF) begin
        s_next.win_cnt = s_reg.win_cnt + 1'b1;
      end
      // delay runs from the first collision; saturates one past the limit
      if ((s_reg.col_cnt != '0) && (s_reg.del_cnt <= 20'(EXCESS_DELAY_CYCLES))) begin
        s_next.del_cnt = s_reg.del_cnt + 1'b1;
      end
      if (mac_evt_i.attempt_start) begin
        s_next.win_cnt = '0;
        s_next.frame_cnt = '0;
      end
      if (mac_evt_i.wire_byte) begin
        s_next.wire_cnt = s_reg.wire_cnt + 1'b1;
        s_next.frame_cnt = s_next.frame_cnt + 1'b1;
      end
      if (mac_evt_i.collision) begin
        s_next.col_cnt = s_reg.col_cnt + 1'b1;
        if (s_reg.win_cnt >= 16'(LATE_WINDOW_CYC)) begin
          s_next.late = 1'b1;
        end
      end
    end
    if (cap) begin
      s_next.active = 1'b0;
      s_next.abort = excess;
      s_next.stat.vlan_tag_flag = frame_info_i.vlan;
      s_next.stat.back_pressure_flag = frame_info_i.back_pressure;
      s_next.stat.pause_frame_flag = frame_info_i.pause;
      s_next.stat.control_frame_flag = frame_info_i.control;
      s_next.stat.wire_bytes = s_next.wire_cnt;
      s_next.stat.underrun_flag = mac_evt_i.underrun;
      s_next.stat.reserved = 1'b0;
      s_next.stat.late_collision_flag = s_next.late;
      s_next.stat.excessive_collision_flag = excess;
      s_next.stat.excessive_delay_flag = s_next.del_cnt > 20'(EXCESS_DELAY_CYCLES);
      s_next.stat.delay_flag = (s_next.del_cnt != '0)
        && (s_next.del_cnt <= 20'(EXCESS_DELAY_CYCLES));
      s_next.stat.broadcast_dest_flag = frame_info_i.bcast;
      s_next.stat.multicast_dest_flag = frame_info_i.mcast;
      s_next.stat.send_success_flag = !finish_abort;
      s_next.stat.type_field_flag = frame_info_i.type_field;
      s_next.stat.length_mismatch_flag = frame_info_i.len_err;
      s_next.stat.crc_mismatch_flag = frame_info_i.crc_err;
      s_next.stat.collision_count = (s_next.col_cnt > 5'(COL_FIELD_MAX)) ?
        COL_FIELD_MAX : s_next.col_cnt[3:0];
      s_next.stat.frame_bytes = s_next.frame_cnt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign host_rdata_o = s_reg.rdata;
  assign mac_rdata_o = s_reg.mac_rdata;
  assign mac_abort_o = s_reg.abort;
  assign mac_end_ptr_o = s_reg.end_ptr;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  ptr_follow_a: assert property (
    seq_push |=> s_reg.end_ptr == 16'($past(s_reg.wr_addr)))
    else $error("end pointer did not follow the written byte");

  byte_store_a: assert property (
    seq_push |=> buf_out_valid)
    else $error("accepted byte not queued for the buffer");

  col_sat_a: assert property (
    cap |=> s_reg.stat.collision_count ==
      ((s_reg.col_cnt > 5'(COL_FIELD_MAX)) ? COL_FIELD_MAX : s_reg.col_cnt[3:0]))
    else $error("collision count field wrong");

  excess_abort_a: assert property (
    s_reg.active && !mac_evt_i.tx_start && mac_evt_i.collision
      && (s_reg.col_cnt == COL_LIMIT - 5'h01)
    |=> mac_abort_o && s_reg.stat.excessive_collision_flag && !s_reg.active)
    else $error("sixteenth collision did not abort");

  delay_excl_a: assert property (
    !(s_reg.stat.delay_flag && s_reg.stat.excessive_delay_flag))
    else $error("delay and excessive delay both set");

  stat_hold_a: assert property (
    !cap |=> $stable(s_reg.stat))
    else $error("status changed outside a capture");

  rsvd_zero_a: assert property (
    host_req_i.rd && (host_req_i.addr == OFF_STAT6) |=> host_rdata_o[7:4] == UNUSED_NIBBLE)
    else $error("unused status six bits not zero");

  ok_abort_a: assert property (
    cap ##0 finish_abort |=> !s_reg.stat.send_success_flag ##1 !mac_abort_o)
    else $error("success flag set on an aborted packet");

  wr_refused_a: assert property (
    host_req_i.wr && (host_req_i.addr == OFF_SEQ_WR) && !host_wr_ready_o
      && !mac_evt_i.tx_start
    |=> $stable(s_reg.end_ptr) && $stable(s_reg.wr_addr))
    else $error("refused write moved the end pointer");

  ram_store_a: assert property (
    ram_we |=> tx_ram[$past(buf_out_data[BW-1:8])] == $past(buf_out_data[7:0]))
    else $error("queued byte not stored in the buffer ram");

  end_hi_wr_a: assert property (
    host_req_i.wr && (host_req_i.addr == OFF_END_HI)
    |=> s_reg.end_ptr[15:8] == $past(host_req_i.wdata))
    else $error("end pointer high byte write lost");

  end_lo_wr_a: assert property (
    host_req_i.wr && (host_req_i.addr == OFF_END_LO)
    |=> s_reg.end_ptr[7:0] == $past(host_req_i.wdata))
    else $error("end pointer low byte write lost");

  end_hold_a: assert property (
    !host_req_i.wr |=> $stable(s_reg.end_ptr))
    else $error("end pointer moved without a write");

  end_rd_a: assert property (
    host_req_i.rd && (host_req_i.addr == OFF_END_HI)
    |=> host_rdata_o == $past(s_reg.end_ptr[15:8]))
    else $error("end pointer high byte read wrong");

  reset_clear_a: assert property (
    $rose(rst_b_i) |-> (s_reg.end_ptr == PTR_RESET) && (s_reg.stat == '0))
    else $error("state not cleared by reset");

  wire_step_a: assert property (
    s_reg.active && !mac_evt_i.tx_start && mac_evt_i.wire_byte
    |=> s_reg.wire_cnt == $past(s_reg.wire_cnt) + 16'h0001)
    else $error("wire byte not counted");

  frame_clear_a: assert property (
    s_reg.active && !mac_evt_i.tx_start && mac_evt_i.attempt_start && !mac_evt_i.wire_byte
    |=> s_reg.frame_cnt == 16'h0000)
    else $error("frame byte count not restarted by a new attempt");

  count_cap_a: assert property (
    cap |=> s_reg.stat.wire_bytes == s_reg.wire_cnt)
    else $error("wire byte total not captured");

  frame_cap_a: assert property (
    cap |=> s_reg.stat.frame_bytes == s_reg.frame_cnt)
    else $error("frame byte count not captured");

  urun_flag_a: assert property (
    cap && mac_evt_i.underrun
    |=> s_reg.stat.underrun_flag && !s_reg.stat.send_success_flag)
    else $error("under-run not reported");

  late_set_a: assert property (
    col_hit && (s_reg.win_cnt >= 16'(LATE_WINDOW_CYC)) |=> s_reg.late)
    else $error("late collision not noted");

  late_cap_a: assert property (
    cap |=> s_reg.stat.late_collision_flag == s_reg.late)
    else $error("late collision flag not captured");

  no_delay_a: assert property (
    cap && (s_reg.col_cnt == 5'h00)
    |=> !s_reg.stat.delay_flag && !s_reg.stat.excessive_delay_flag)
    else $error("delay reported without a collision");

  exdel_set_a: assert property (
    cap && !mac_evt_i.tx_start && (s_reg.del_cnt > 20'(EXCESS_DELAY_CYCLES))
    |=> s_reg.stat.excessive_delay_flag)
    else $error("excessive delay not reported");

  kind_cap_a: assert property (
    cap |=> {s_reg.stat.pause_frame_flag, s_reg.stat.control_frame_flag}
      == $past({frame_info_i.pause, frame_info_i.control}))
    else $error("frame kind flags not captured");

  dest_cap_a: assert property (
    cap |=> {s_reg.stat.broadcast_dest_flag, s_reg.stat.multicast_dest_flag}
      == $past({frame_info_i.bcast, frame_info_i.mcast}))
    else $error("destination flags not captured");

  err_cap_a: assert property (
    cap |=> {s_reg.stat.length_mismatch_flag, s_reg.stat.crc_mismatch_flag}
      == $past({frame_info_i.len_err, frame_info_i.crc_err}))
    else $error("error flags not captured");

  rsvd_bit_a: assert property (
    !s_reg.stat.reserved)
    else $error("reserved status bit set");

  abort_pulse_a: assert property (
    mac_abort_o |=> !mac_abort_o)
    else $error("abort pulse longer than one cycle");

endmodule

`default_nettype wire

/* dv/tbfsv_mac_model.sv */
/*
  behavioural mac at the far side of the block: event pulses, frame info and
  ram reads. assumes the bench calls its tasks; it drives on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module tbfsv_mac_model
  import tbfsv_pkg::*;
#(
  parameter int AW = 4
) (
  // clock
  input wire logic clk_i,
  // to the block
  output tbfsv_mac_evt_t mac_evt_o,
  output tbfsv_frame_info_t frame_info_o,
  output logic mac_rd_o,
  output logic [AW-1:0] mac_rd_addr_o,
  // from the block
  input wire logic [7:0] mac_rdata_i
);
  initial begin
    mac_evt_o = '0;
    frame_info_o = '0;
    mac_rd_o = 1'b0;
    mac_rd_addr_o = '0;
  end

  // info is only valid beside the pulse, so it flips afterwards
  task automatic ev(input logic [5:0] e, input logic [8:0] info);
    @(negedge clk_i);
    mac_evt_o = tbfsv_mac_evt_t'(e);
    frame_info_o = tbfsv_frame_info_t'(info);
    @(negedge clk_i);
    mac_evt_o = '0;
    frame_info_o = ~frame_info_o;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
    @(negedge clk_i);
    mac_rd_o = 1'b1;
    mac_rd_addr_o = a;
    @(negedge clk_i);
    d = mac_rdata_i;
    mac_rd_o = 1'b0;
    mac_rd_addr_o = ~a;
  endtask

  // a held read starves the buffer drain
  task automatic hold(input int n);
    @(negedge clk_i);
    mac_rd_o = 1'b1;
    repeat (n) @(negedge clk_i);
    mac_rd_o = 1'b0;
  endtask
endmodule

`default_nettype wire

/* dv/tbfsv_top_tb.sv */
/*
  self-checking bench for the fill port, end pointer and status vector.
  assumes the mac model in tbfsv_mac_model and a shortened delay threshold.
*/
`timescale 1ns/1ps
`default_nettype none

module tbfsv_top_tb;
  import tbfsv_pkg::*;
  localparam int AW = 4;
  localparam int XD = 200;
  localparam logic [5:0] E_START = 6'h20;
  localparam logic [5:0] E_ATT = 6'h10;
  localparam logic [5:0] E_BYTE = 6'h08;
  localparam logic [5:0] E_COL = 6'h04;
  localparam logic [5:0] E_URUN = 6'h02;
  localparam logic [5:0] E_END = 6'h01;
  localparam int NC [0:5] = '{0, 2, 15, 16, 1, 0};
  localparam int NB [0:5] = '{5, 3, 1, 1, 2, 4};
  localparam int PRE [0:5] = '{0, 0, 0, 0, 1300, 0};
  localparam int POST [0:5] = '{0, 0, 0, 0, 250, 0};
  localparam logic [7:0] MISC [0:3] = '{OFF_SEQ_WR, OFF_END_HI, OFF_END_LO, 8'h10};
  logic clk_i;
  logic rst_b_i;
  tbfsv_host_req_t req;
  tbfsv_mac_evt_t evt;
  tbfsv_frame_info_t info;
  logic wr_rdy;
  logic mac_rd;
  logic abort;
  logic [7:0] rdata;
  logic [7:0] mac_rdata;
  logic [AW-1:0] mac_addr;
  logic [15:0] end_ptr;
  logic [7:0] mem [0:15];
  integer fails = 0;
  integer comparisons = 0;
  integer seed = 32'h071b;
  integer idx = 0;
  integer aborts = 0;

  tbfsv_top #(.BUF_AW(AW), .EXCESS_DELAY_CYCLES(XD)) u_tbfsv_top (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .host_req_i(req), .host_wr_ready_o(wr_rdy),
    .host_rdata_o(rdata), .mac_evt_i(evt), .frame_info_i(info), .mac_rd_i(mac_rd),
    .mac_rd_addr_i(mac_addr), .mac_rdata_o(mac_rdata), .mac_abort_o(abort),
    .mac_end_ptr_o(end_ptr));

  tbfsv_mac_model #(.AW(AW)) u_tbfsv_mac_model (
    .clk_i(clk_i), .mac_evt_o(evt), .frame_info_o(info), .mac_rd_o(mac_rd),
    .mac_rd_addr_o(mac_addr), .mac_rdata_i(mac_rdata));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (abort === 1'b1) aborts <= aborts + 1;

  // -------------------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------------------
  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons = comparisons + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic hchk(input string n, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_i);
    req.rd = 1'b0;
    cmp(n, {8'h00, e}, {8'h00, rdata});
  endtask

  task automatic hwr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(negedge clk_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    while (wr_rdy !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    // a write that is never accepted counts against the run
    if (n >= 100) fails = fails + 1;
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask

  task automatic seqwr(input logic [7:0] v);
    hwr(OFF_SEQ_WR, v);
    mem[idx] = v;
    hchk("end high", OFF_END_HI, 8'(idx >> 8));
    hchk("end low", OFF_END_LO, 8'(idx));
    cmp("end ptr", 16'(idx), end_ptr);
    idx++;
  endtask

  task automatic ramchk(input int lo, input int hi);
    logic [7:0] d;
    for (int i = lo; i <= hi; i++) begin
      u_tbfsv_mac_model.rd(AW'(i), d);
      cmp("ram", {8'h00, mem[i]}, {8'h00, d});
    end
  endtask

  task automatic chk_stat(input tbfsv_stat_t e);
    logic [55:0] v;
    v = {4'h0, e};
    for (int i = 0; i < 7; i++) hchk("status", 8'(OFF_STAT0 - i), v[8*i +: 8]);
  endtask

  task automatic frame(input int nc, input int nb, input int pre, input int post, input bit ur);
    tbfsv_stat_t e;
    logic [8:0] fi;
    int a0;
    fi = 9'($random(seed));
    a0 = aborts;
    idx = 0;
    u_tbfsv_mac_model.ev(E_START, fi);
    for (int a = 0; a < 17; a++) begin
      if (a > 0) u_tbfsv_mac_model.ev(E_ATT, fi);
      repeat (nb) u_tbfsv_mac_model.ev(E_BYTE, fi);
      if (a == nc) break;
      if (a == 0) repeat (pre) @(negedge clk_i);
      u_tbfsv_mac_model.ev(E_COL, fi);
      if (a == 15) break;
    end
    if (nc < 16) begin
      repeat (post) @(negedge clk_i);
      u_tbfsv_mac_model.ev(ur ? E_URUN : E_END, fi);
    end
    // stray events after capture must leave the vector alone
    u_tbfsv_mac_model.ev(E_BYTE, fi);
    u_tbfsv_mac_model.ev(E_COL, fi);
    e = '0;
    {e.vlan_tag_flag, e.back_pressure_flag, e.pause_frame_flag, e.control_frame_flag,
     e.broadcast_dest_flag, e.multicast_dest_flag, e.type_field_flag,
     e.length_mismatch_flag, e.crc_mismatch_flag} = fi;
    e.wire_bytes = 16'((nc > 15 ? 16 : nc + 1) * nb);
    e.frame_bytes = 16'(nb);
    e.collision_count = 4'(nc > 15 ? 15 : nc);
    e.excessive_collision_flag = nc > 15;
    e.underrun_flag = ur;
    e.send_success_flag = !ur && nc < 16;
    e.late_collision_flag = nc > 0 && pre > 1280;
    e.excessive_delay_flag = nc > 0 && post > XD;
    e.delay_flag = nc > 0 && post <= XD;
    chk_stat(e);
    cmp("abort", 16'(nc > 15), 16'(aborts - a0));
  endtask

  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------------------
  initial begin
    req = '0;
    rst_b_i = 1'b0;
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk_stat('0);
    for (int i = 0; i < 4; i++) hchk("reset", MISC[i], 8'h00);
    $display("test reset done");
    repeat (4) seqwr(8'($random(seed)));
    ramchk(0, 3);
    hwr(OFF_END_HI, 8'hA5);
    hwr(OFF_END_LO, 8'h3C);
    hchk("end high", OFF_END_HI, 8'hA5);
    hchk("end low", OFF_END_LO, 8'h3C);
    cmp("end ptr", 16'hA53C, end_ptr);
    hwr(OFF_STAT6, 8'hFF);
    hchk("status six", OFF_STAT6, 8'h00);
    $display("test registers done");
    fork
      u_tbfsv_mac_model.hold(40);
    join_none
    seqwr(8'h5A);
    seqwr(8'hC3);
    @(negedge clk_i);
    cmp("ready", 16'h0000, {15'h0000, wr_rdy});
    repeat (40) @(negedge clk_i);
    ramchk(4, 5);
    $display("test stall done");
    for (int i = 0; i < 6; i++) begin
      frame(NC[i], NB[i], PRE[i], POST[i], i == 5);
      $display("test frame %0d done", i);
    end
    seqwr(8'h77);
    give_verdict();
  end

  initial begin
    #(40 * 20000);
    fails = fails + 1;
    give_verdict();
  end
endmodule

`default_nettype wire
